// [inc/pmc_pkg.sv]
package pmc_pkg;
	// Clock rate and the second derived from it
	localparam int          PMC_SECOND_NS          = 1_000_000_000;
	localparam int          PMC_CLK_PERIOD_NS      = 100;
	localparam int          PMC_CYCLES_PER_SECOND  = PMC_SECOND_NS / PMC_CLK_PERIOD_NS;
	localparam int          PMC_DIV_W              = 24;

	// Time-of-day layout: quarter index and second within quarter
	localparam int          PMC_QTR_W              = 7;
	localparam int          PMC_QSEC_W             = 10;
	localparam int          PMC_DAY_W              = 17;
	localparam logic [9:0]  PMC_QSEC_MAX           = 10'h0383;
	localparam logic [6:0]  PMC_QTR_MAX            = 7'h5F;
	localparam logic [9:0]  PMC_PM_DELAY_SEC       = 10'h000A;
	localparam logic [9:0]  PMC_QSEC_BORROW        = 10'h037A;
	localparam logic [16:0] PMC_DAY_SECONDS        = 17'h1_5180;

	// Reset values: element time 00:00:00, so delayed time is 23:59:50
	localparam logic [6:0]  PMC_PM_RESET_QTR       = 7'h5F;
	localparam logic [9:0]  PMC_PM_RESET_QSEC      = 10'h037A;
	localparam logic [6:0]  PMC_DAY_START_DEFAULT  = 7'h00;

	// Severe-second thresholds
	localparam int          PMC_EBC_W              = 16;
	localparam logic [15:0] PMC_THR_RS1            = 16'h0960;
	localparam logic [15:0] PMC_THR_MS1            = 16'h7080;
	localparam logic [15:0] PMC_THR_VC4_64C        = 16'h0960;
	localparam logic [15:0] PMC_THR_TWO_MBIT_FAS   = 16'h001C;
	localparam logic [15:0] PMC_THR_TWO_MBIT_CRC   = 16'h0325;
	localparam logic [15:0] PMC_EBC_ONE            = 16'h0001;

	// Network layer the near-end primitives come from
	typedef enum logic [1:0] {
		PMC_LAYER_RS1,
		PMC_LAYER_MS1,
		PMC_LAYER_VC4_64C,
		PMC_LAYER_TWO_MBIT
	} pmc_layer_t;

	// Layer-specific near_severe_threshold
	function automatic logic [15:0] pmc_threshold(input pmc_layer_t layer, input logic [15:0] crc_thr);
		logic [15:0] thr;
		thr = PMC_THR_RS1;
		case (layer)
			PMC_LAYER_RS1:      thr = PMC_THR_RS1;
			PMC_LAYER_MS1:      thr = PMC_THR_MS1;
			PMC_LAYER_VC4_64C:  thr = PMC_THR_VC4_64C;
			PMC_LAYER_TWO_MBIT: thr = crc_thr;
			default:            thr = PMC_THR_RS1;
		endcase
		return thr;
	endfunction
endpackage

// [logic/pmc_clock_events.sv]
`timescale 1ns/1ps
module pmc_clock_events #(
	parameter int          CYCLES_PER_SECOND      = pmc_pkg::PMC_CYCLES_PER_SECOND,
	parameter logic [15:0] TWO_MBIT_CRC_THRESHOLD = pmc_pkg::PMC_THR_TWO_MBIT_CRC
) (
	// Clock and reset
	input  wire logic                                  ref_clk_in,
	input  wire logic                                  arst_n_in,
	// Element time-of-day preset
	input  wire logic                                  tod_preset_in,
	input  wire logic [pmc_pkg::PMC_QTR_W-1:0]         tod_preset_quarter_in,
	input  wire logic [pmc_pkg::PMC_QSEC_W-1:0]        tod_preset_qsec_in,
	// Day period start selection
	input  wire logic                                  day_start_load_in,
	input  wire logic [pmc_pkg::PMC_QTR_W-1:0]         day_period_start_select_in,
	// Near-end primitives
	input  wire pmc_pkg::pmc_layer_t                   layer_select_in,
	input  wire logic                                  near_defect_second_in,
	input  wire logic                                  near_ds_connected_in,
	input  wire logic [pmc_pkg::PMC_EBC_W-1:0]         near_errored_block_count_in,
	input  wire logic                                  near_ebc_connected_in,
	input  wire logic                                  multiframe_present_in,
	// Time base outputs
	output logic                                       one_second_tick_out,
	output logic [pmc_pkg::PMC_QTR_W-1:0]              delayed_pm_quarter_out,
	output logic [pmc_pkg::PMC_QSEC_W-1:0]             delayed_pm_qsec_out,
	output logic                                       quarter_hour_tick_out,
	output logic                                       day_tick_out,
	output logic [pmc_pkg::PMC_QTR_W-1:0]              day_start_quarter_out,
	output logic                                       time_preset_out,
	// Near-end events
	output logic                                       near_errored_second_out,
	output logic                                       near_severe_errored_second_out,
	output logic [pmc_pkg::PMC_EBC_W-1:0]              near_background_block_errors_out,
	output logic                                       near_event_valid_out
);
	import pmc_pkg::*;

	localparam logic [PMC_DIV_W-1:0] DIV_LAST = PMC_DIV_W'(CYCLES_PER_SECOND - 1);

	logic [PMC_DIV_W-1:0]  sec_div;
	logic                  sec_end;
	logic                  qtr_end;
	logic [6:0]            next_quarter;
	logic [6:0]            pm_quarter;
	logic [9:0]            pm_qsec;
	logic                  preset_ok;
	logic [6:0]            preset_quarter;
	logic [9:0]            preset_qsec;
	logic [6:0]            day_start;

	// A preset outside the day would corrupt both counters, so it is dropped
	assign preset_ok = tod_preset_in && (tod_preset_quarter_in <= PMC_QTR_MAX)
		&& (tod_preset_qsec_in <= PMC_QSEC_MAX);

	// Delayed time is the preset minus ten seconds, borrowing across quarters
	always_comb begin
		if (tod_preset_qsec_in >= PMC_PM_DELAY_SEC) begin
			preset_qsec    = tod_preset_qsec_in - PMC_PM_DELAY_SEC;
			preset_quarter = tod_preset_quarter_in;
		end else begin
			preset_qsec    = tod_preset_qsec_in + PMC_QSEC_BORROW;
			preset_quarter = (tod_preset_quarter_in == '0) ? PMC_QTR_MAX : tod_preset_quarter_in - 7'h01;
		end
	end

	// Divider from the reference clock down to one second
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sec_div <= '0;
		end else if (preset_ok || sec_div == DIV_LAST) begin
			sec_div <= '0; // Preset restarts the second so it aligns with the new time
		end else begin
			sec_div <= sec_div + 1'b1;
		end
	end

	assign sec_end      = (sec_div == DIV_LAST) && !preset_ok;
	assign qtr_end      = sec_end && (pm_qsec == PMC_QSEC_MAX);
	assign next_quarter = (pm_quarter == PMC_QTR_MAX) ? '0 : pm_quarter + 7'h01;

	// Second strobe toward the atomic functions
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			one_second_tick_out <= 1'b0;
		end else begin
			one_second_tick_out <= sec_end;
		end
	end

	// Delayed monitoring time, kept as quarter plus second in quarter
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pm_quarter <= PMC_PM_RESET_QTR;
			pm_qsec    <= PMC_PM_RESET_QSEC;
		end else if (preset_ok) begin
			pm_quarter <= preset_quarter;
			pm_qsec    <= preset_qsec;
		end else if (qtr_end) begin
			pm_quarter <= next_quarter;
			pm_qsec    <= '0;
		end else if (sec_end) begin
			pm_qsec <= pm_qsec + 10'h001;
		end
	end

	assign delayed_pm_quarter_out = pm_quarter;
	assign delayed_pm_qsec_out    = pm_qsec;

	// Day start choice is held until the manager changes it
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			day_start <= PMC_DAY_START_DEFAULT;
		end else if (day_start_load_in && day_period_start_select_in <= PMC_QTR_MAX) begin
			day_start <= day_period_start_select_in;
		end
	end

	assign day_start_quarter_out = day_start;

	// Period ticks share the cycle of the second tick that closes them
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			quarter_hour_tick_out <= 1'b0;
			day_tick_out          <= 1'b0;
		end else begin
			quarter_hour_tick_out <= qtr_end;
			day_tick_out          <= qtr_end && (next_quarter == day_start);
		end
	end

	// Status: time has been preset since reset
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			time_preset_out <= 1'b0;
		end else if (preset_ok) begin
			time_preset_out <= 1'b1;
		end
	end

	// Near-end events, evaluated on the same second strobe
	pmc_near_event #(
		.TWO_MBIT_CRC_THRESHOLD (TWO_MBIT_CRC_THRESHOLD)
	) u_near (
		.ref_clk_in                       (ref_clk_in),
		.arst_n_in                        (arst_n_in),
		.one_second_tick_in               (sec_end),
		.layer_select_in                  (layer_select_in),
		.near_defect_second_in            (near_defect_second_in),
		.near_ds_connected_in             (near_ds_connected_in),
		.near_errored_block_count_in      (near_errored_block_count_in),
		.near_ebc_connected_in            (near_ebc_connected_in),
		.multiframe_present_in            (multiframe_present_in),
		.near_errored_second_out          (near_errored_second_out),
		.near_severe_errored_second_out   (near_severe_errored_second_out),
		.near_background_block_errors_out (near_background_block_errors_out),
		.near_event_valid_out             (near_event_valid_out)
	);

	// Helper counters for period length checks
	logic [9:0]  chk_qsec_cnt;
	logic [16:0] chk_day_cnt;
	logic        chk_qtr_full;
	logic        chk_day_full;
	logic [16:0] chk_div_cnt;

	// Seconds seen since the last quarter end; valid only after a full period
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chk_qsec_cnt <= '0;
			chk_qtr_full <= 1'b0;
		end else if (preset_ok) begin
			chk_qsec_cnt <= '0;
			chk_qtr_full <= 1'b0;
		end else if (qtr_end) begin
			chk_qsec_cnt <= '0;
			chk_qtr_full <= 1'b1;
		end else if (sec_end) begin
			chk_qsec_cnt <= chk_qsec_cnt + 10'h001;
		end
	end

	// Seconds seen since the last day end
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chk_day_cnt  <= '0;
			chk_day_full <= 1'b0;
		end else if (preset_ok || day_start_load_in) begin
			chk_day_cnt  <= '0;
			chk_day_full <= 1'b0;
		end else if (qtr_end && next_quarter == day_start) begin
			chk_day_cnt  <= '0;
			chk_day_full <= 1'b1;
		end else if (sec_end) begin
			chk_day_cnt <= chk_day_cnt + 17'h0_0001;
		end
	end

	// Cycles since the last second tick, saturating
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chk_div_cnt <= '0;
		end else if (sec_end || preset_ok) begin
			chk_div_cnt <= '0;
		end else if (chk_div_cnt != '1) begin
			chk_div_cnt <= chk_div_cnt + 17'h0_0001;
		end
	end

	AST_SECOND_SPACING: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		sec_end && chk_div_cnt != '1 && !$past(preset_ok) |-> chk_div_cnt == 17'(CYCLES_PER_SECOND - 1))
		else $error("Second tick spacing differs from the divider length");

	AST_QUARTER_LENGTH: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		qtr_end && chk_qtr_full |-> chk_qsec_cnt == PMC_QSEC_MAX)
		else $error("Quarter period is not 900 seconds");

	AST_DAY_LENGTH: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		qtr_end && next_quarter == day_start && chk_day_full |-> chk_day_cnt == PMC_DAY_SECONDS - 17'h0_0001)
		else $error("Day period is not 86400 seconds");

	AST_QTR_WITH_SECOND: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		quarter_hour_tick_out |-> one_second_tick_out ##1 !quarter_hour_tick_out)
		else $error("Quarter tick not a single cycle with the second tick");

	AST_DAY_ON_QUARTER: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		day_tick_out |-> quarter_hour_tick_out && pm_qsec == '0 && pm_quarter == day_start)
		else $error("Day tick away from the selected quarter boundary");

	AST_QUARTER_ABUTS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		quarter_hour_tick_out |-> pm_qsec == '0 && pm_quarter == $past(next_quarter))
		else $error("New quarter does not start where the old one ended");

	AST_PRESET_DELAY: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		preset_ok && tod_preset_qsec_in >= PMC_PM_DELAY_SEC
		|=> pm_qsec == $past(tod_preset_qsec_in) - PMC_PM_DELAY_SEC && pm_quarter == $past(tod_preset_quarter_in))
		else $error("Delayed time does not lag the preset by ten seconds");

	AST_DAY_DEFAULT: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!time_preset_out && !$past(day_start_load_in, 1) && qtr_end && pm_quarter == PMC_QTR_MAX
		&& day_start == PMC_DAY_START_DEFAULT |=> day_tick_out)
		else $error("Day tick missing at default midnight");

	AST_EVENT_ON_SECOND: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		near_event_valid_out |-> one_second_tick_out)
		else $error("Near-end results refreshed off the second tick");

	// Further time-base checks; the single-cycle ones rely on CYCLES_PER_SECOND of two or more
	AST_DIV_IN_RANGE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		sec_div <= DIV_LAST)
		else $error("Second divider ran past its last value");

	AST_SECOND_SINGLE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		one_second_tick_out |=> !one_second_tick_out)
		else $error("Second tick lasted more than one cycle");

	AST_PRESET_RESTARTS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		preset_ok |=> time_preset_out && !one_second_tick_out)
		else $error("Accepted preset did not restart the second");

	AST_SECOND_ADVANCES: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		one_second_tick_out && !quarter_hour_tick_out |-> pm_qsec == $past(pm_qsec) + 10'h001)
		else $error("Delayed time did not advance by one second");

	AST_PRESET_BORROW: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		preset_ok && tod_preset_qsec_in < PMC_PM_DELAY_SEC |=> pm_qsec == $past(tod_preset_qsec_in) + PMC_QSEC_BORROW
		&& (pm_quarter == PMC_QTR_MAX ? $past(tod_preset_quarter_in) == '0
		: pm_quarter + 7'h01 == $past(tod_preset_quarter_in)))
		else $error("Borrowed preset does not lag by ten seconds");

	AST_PRESET_REFUSED: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		tod_preset_in && !preset_ok && !sec_end
		|=> $stable(pm_qsec) && $stable(pm_quarter) && $stable(time_preset_out))
		else $error("Out-of-range preset disturbed the delayed time");

	AST_TIME_IN_RANGE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		pm_qsec <= PMC_QSEC_MAX && pm_quarter <= PMC_QTR_MAX && day_start <= PMC_QTR_MAX)
		else $error("Delayed time or day start outside the day");

	AST_QTR_AFTER_WRAP: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		quarter_hour_tick_out |-> $past(pm_qsec) == PMC_QSEC_MAX)
		else $error("Quarter tick without the last second of the quarter");

	AST_DAY_ONLY_AT_START: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		quarter_hour_tick_out && pm_quarter != day_start && !$past(day_start_load_in) |-> !day_tick_out)
		else $error("Day tick at a quarter other than the selected start");

	AST_DAY_START_REFUSED: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		day_start_load_in && day_period_start_select_in > PMC_QTR_MAX |=> $stable(day_start))
		else $error("Out-of-range day start was taken");

	AST_VALID_SINGLE: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		near_event_valid_out |=> !near_event_valid_out)
		else $error("Near-end valid lasted more than one cycle");

	COV_QUARTER_TICK: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		quarter_hour_tick_out);
	COV_DAY_TICK_NONZERO: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		day_tick_out && day_start != '0);
	COV_PRESET_BORROW: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		preset_ok && tod_preset_qsec_in < PMC_PM_DELAY_SEC);
	COV_SEVERE: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		near_event_valid_out && near_severe_errored_second_out);
	COV_PRESET_REFUSED: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		tod_preset_in && !preset_ok);
endmodule

// [logic/pmc_near_event.sv]
`timescale 1ns/1ps
module pmc_near_event #(
	parameter logic [15:0] TWO_MBIT_CRC_THRESHOLD = pmc_pkg::PMC_THR_TWO_MBIT_CRC
) (
	// Clock and reset
	input  wire logic                                  ref_clk_in,
	input  wire logic                                  arst_n_in,
	// Second strobe and layer
	input  wire logic                                  one_second_tick_in,
	input  wire pmc_pkg::pmc_layer_t                   layer_select_in,
	// Primitives of the closing second
	input  wire logic                                  near_defect_second_in,
	input  wire logic                                  near_ds_connected_in,
	input  wire logic [pmc_pkg::PMC_EBC_W-1:0]         near_errored_block_count_in,
	input  wire logic                                  near_ebc_connected_in,
	input  wire logic                                  multiframe_present_in,
	// Per-second events
	output logic                                       near_errored_second_out,
	output logic                                       near_severe_errored_second_out,
	output logic [pmc_pkg::PMC_EBC_W-1:0]              near_background_block_errors_out,
	output logic                                       near_event_valid_out
);
	import pmc_pkg::*;

	logic              ds;
	logic [15:0]       ebc;
	logic [15:0]       thr;
	logic              two_mbit;
	logic              next_es;
	logic              next_ses;

	// Missing inputs are neutral, so an unwired layer reports clean seconds
	assign ds       = near_defect_second_in & near_ds_connected_in;
	assign ebc      = near_ebc_connected_in ? near_errored_block_count_in : '0;
	assign thr      = pmc_threshold(layer_select_in, TWO_MBIT_CRC_THRESHOLD);
	assign two_mbit = (layer_select_in == PMC_LAYER_TWO_MBIT);

	// Event decisions from this second's primitives
	always_comb begin
		next_es = ds | (ebc >= PMC_EBC_ONE);
		if (two_mbit) begin
			next_ses = ds | ((ebc >= thr) & multiframe_present_in)
				| ((ebc >= PMC_THR_TWO_MBIT_FAS) & ~multiframe_present_in);
		end else begin
			next_ses = ds | (ebc >= thr);
		end
	end

	// Results are held for the whole second that follows the tick
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			near_errored_second_out          <= 1'b0;
			near_severe_errored_second_out   <= 1'b0;
			near_background_block_errors_out <= '0;
		end else if (one_second_tick_in) begin
			near_errored_second_out        <= next_es;
			near_severe_errored_second_out <= next_ses;
			if (!next_ses && (!two_mbit || multiframe_present_in)) begin
				near_background_block_errors_out <= ebc;
			end else begin
				near_background_block_errors_out <= '0;
			end
		end
	end

	// Marks the cycle in which fresh results appear
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			near_event_valid_out <= 1'b0;
		end else begin
			near_event_valid_out <= one_second_tick_in;
		end
	end

	AST_NES_FROM_PRIMITIVES: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		one_second_tick_in |=> near_errored_second_out == $past(ds | (ebc != '0)))
		else $error("Errored second does not follow the primitives");

	AST_SES_TWO_MBIT_FAS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		one_second_tick_in && two_mbit && !multiframe_present_in && ebc >= PMC_THR_TWO_MBIT_FAS
		|=> near_severe_errored_second_out)
		else $error("Two-mbit count of 28 without multiframe was not severe");

	AST_BBE_ZERO_IN_SES: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		near_severe_errored_second_out |-> near_background_block_errors_out == '0)
		else $error("Background errors reported in a severe second");

	AST_HOLD_BETWEEN_TICKS: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!one_second_tick_in |=> $stable(near_errored_second_out) && $stable(near_background_block_errors_out))
		else $error("Near-end results changed without a second tick");
endmodule

// [sim/pmc_testbench.sv]
`timescale 1ns/1ps
module testbench;
	import pmc_pkg::*;
	localparam int CPS = 20;
	logic             ref_clk, arst_n, tod_preset, day_load, tick, qtick, dtick, tpre, es, ses, valid;
	logic [6:0]       pre_q, day_sel, pm_q, ds_q;
	logic [9:0]       pre_s, pm_s;
	logic [15:0]      bbe, ebc_w, p_ebc;
	logic             ds_w, mfp_w, dsc_w, ebcc_w, p_ds, p_mfp, p_dsc, p_ebcc;
	pmc_layer_t       layer;
	int               bad_count, comparisons, stray;

	pmc_clock_events #(.CYCLES_PER_SECOND(CPS)) dut_u (
		.ref_clk_in(ref_clk), .arst_n_in(arst_n), .tod_preset_in(tod_preset), .tod_preset_quarter_in(pre_q),
		.tod_preset_qsec_in(pre_s), .day_start_load_in(day_load), .day_period_start_select_in(day_sel),
		.layer_select_in(layer), .near_defect_second_in(ds_w), .near_ds_connected_in(dsc_w),
		.near_errored_block_count_in(ebc_w), .near_ebc_connected_in(ebcc_w), .multiframe_present_in(mfp_w),
		.one_second_tick_out(tick), .delayed_pm_quarter_out(pm_q), .delayed_pm_qsec_out(pm_s),
		.quarter_hour_tick_out(qtick), .day_tick_out(dtick), .day_start_quarter_out(ds_q), .time_preset_out(tpre),
		.near_errored_second_out(es), .near_severe_errored_second_out(ses),
		.near_background_block_errors_out(bbe), .near_event_valid_out(valid));

	pmc_tf_model pm_u (
		.ref_clk_in(ref_clk), .arst_n_in(arst_n), .one_second_tick_in(tick), .ds_in(p_ds), .ebc_in(p_ebc),
		.mfp_in(p_mfp), .ds_con_in(p_dsc), .ebc_con_in(p_ebcc), .near_defect_second_out(ds_w),
		.near_errored_block_count_out(ebc_w), .multiframe_present_out(mfp_w), .near_ds_connected_out(dsc_w),
		.near_ebc_connected_out(ebcc_w));

	// Free-running reference clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task print_verdict();
		$display("Counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Settle point just after an edge; period ticks outside a second tick are tallied as strays
	task wait_sec(output int cyc);
		cyc = 0;
		do begin
			@(posedge ref_clk);
			#1;
			cyc++;
			if ((qtick === 1'b1 || dtick === 1'b1) && tick !== 1'b1) stray++;
		end while (tick !== 1'b1 && cyc < 100);
	endtask

	task preset(input logic [6:0] q, input logic [9:0] s);
		@(posedge ref_clk);
		tod_preset <= 1'b1;
		pre_q      <= q;
		pre_s      <= s;
		@(posedge ref_clk);
		tod_preset <= 1'b0;
		#1;
	endtask

	task load_start(input logic [6:0] sel);
		@(posedge ref_clk);
		day_load <= 1'b1;
		day_sel  <= sel;
		@(posedge ref_clk);
		day_load <= 1'b0;
		#1;
	endtask

	// Untouched time base: lag, first quarter after ten seconds, then a full quarter
	task t_quarter();
		int secs, cyc, k;
		check(pm_q, 7'h5F);
		check(pm_s, 10'h037A);
		check(ds_q, 7'h00);
		for (k = 0; k < 2; k++) begin
			secs = 0;
			do begin
				wait_sec(cyc);
				secs++;
			end while (qtick !== 1'b1 && secs < 1000);
			check(secs, k ? 900 : 10);
			check(dtick, k ? 1'b0 : 1'b1);
			check({pm_q, pm_s}, {k[6:0], 10'h0000});
			if (k == 1) check(cyc, CPS);
		end
		check(stray, 0);
	endtask

	// Preset with a borrow across the quarter and across midnight, then two out-of-range presets that are dropped
	task t_preset();
		preset(7'h04, 10'h0005);
		check({pm_q, pm_s, tpre}, {7'h03, 10'h037F, 1'b1});
		preset(7'h00, 10'h0003);
		check({pm_q, pm_s}, {7'h5F, 10'h037D});
		preset(7'h60, 10'h0005);
		check({pm_q, pm_s}, {7'h5F, 10'h037D});
		preset(7'h01, 10'h0384);
		check({pm_q, pm_s}, {7'h5F, 10'h037D});
	endtask

	// Day start at quarter four; an out-of-range select must not disturb it
	task t_day_start();
		int cyc;
		load_start(7'h04);
		check(ds_q, 7'h04);
		load_start(7'h64);
		check(ds_q, 7'h04);
		preset(7'h04, 10'h0009);
		wait_sec(cyc);
		check({qtick, dtick, pm_q}, {1'b1, 1'b1, 7'h04});
		preset(7'h06, 10'h0009);
		wait_sec(cyc);
		check({qtick, dtick}, {1'b1, 1'b0});
	endtask

	// One second of primitives through the model, then the judged result
	task ev_case(input pmc_layer_t ly, input logic d, input logic [15:0] n, input logic m, input logic dc,
			input logic nc);
		int cyc;
		logic [15:0] c, thr;
		logic e_d, e_ses;
		@(posedge ref_clk);
		layer  <= ly;
		p_ds   <= d;
		p_ebc  <= n;
		p_mfp  <= m;
		p_dsc  <= dc;
		p_ebcc <= nc;
		wait_sec(cyc);
		wait_sec(cyc);
		e_d   = d & dc;
		c     = nc ? n : 16'h0000;
		thr   = (ly == PMC_LAYER_MS1) ? 16'h7080 : (ly == PMC_LAYER_TWO_MBIT) ? 16'h0325 : 16'h0960;
		e_ses = e_d | ((ly == PMC_LAYER_TWO_MBIT) ? ((c >= thr && m) || (c >= 16'h001C && !m)) : (c >= thr));
		check(valid, 1'b1);
		check(es, e_d | (c >= 16'h0001));
		check(ses, e_ses);
		check(bbe, (!e_ses && (ly != PMC_LAYER_TWO_MBIT || m)) ? c : 16'h0000);
	endtask

	task t_events();
		ev_case(PMC_LAYER_RS1, 1'b0, 16'h095F, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_RS1, 1'b0, 16'h0960, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_MS1, 1'b0, 16'h707F, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_MS1, 1'b0, 16'h7080, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_VC4_64C, 1'b0, 16'h095F, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_VC4_64C, 1'b0, 16'h0960, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_TWO_MBIT, 1'b0, 16'h001B, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_TWO_MBIT, 1'b0, 16'h001C, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_TWO_MBIT, 1'b0, 16'h0324, 1'b1, 1'b1, 1'b1);
		ev_case(PMC_LAYER_TWO_MBIT, 1'b0, 16'h0325, 1'b1, 1'b1, 1'b1);
		ev_case(PMC_LAYER_RS1, 1'b1, 16'h0000, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_RS1, 1'b0, 16'h0001, 1'b0, 1'b1, 1'b1);
		ev_case(PMC_LAYER_RS1, 1'b1, 16'h01F4, 1'b0, 1'b0, 1'b0);
	endtask

	// Watchdog sized well above the quarter-hour run
	initial begin
		repeat (40000) @(posedge ref_clk);
		bad_count++;
		$display("Error at %0t: watchdog expired", $time);
		print_verdict();
	end

	// Reset, then the scenarios in turn
	initial begin
		{arst_n, tod_preset, day_load, p_ds, p_mfp, p_dsc, p_ebcc} = '0;
		{pre_q, pre_s, day_sel, p_ebc} = '0;
		layer = PMC_LAYER_RS1;
		bad_count = 0;
		comparisons = 0;
		stray = 0;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		#1;
		t_quarter();
		t_preset();
		t_day_start();
		t_events();
		print_verdict();
	end
endmodule

// [sim/pmc_tf_model.sv]
`timescale 1ns/1ps
// Transport function stand-in: presents one second's primitives, refreshed at each second tick
module pmc_tf_model (
	// Clock, reset and second strobe
	input  wire logic        ref_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        one_second_tick_in,
	// Values to present for the coming second
	input  wire logic        ds_in,
	input  wire logic [15:0] ebc_in,
	input  wire logic        mfp_in,
	input  wire logic        ds_con_in,
	input  wire logic        ebc_con_in,
	// Primitives towards the block
	output logic             near_defect_second_out,
	output logic [15:0]      near_errored_block_count_out,
	output logic             multiframe_present_out,
	output logic             near_ds_connected_out,
	output logic             near_ebc_connected_out
);
	// A new second starts on the tick; an unwired line floats to junk that the block must ignore
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			near_defect_second_out       <= 1'b0;
			near_errored_block_count_out <= 16'h0000;
			multiframe_present_out       <= 1'b0;
			near_ds_connected_out        <= 1'b0;
			near_ebc_connected_out       <= 1'b0;
		end else if (one_second_tick_in) begin
			near_defect_second_out       <= ds_con_in ? ds_in : 1'b1;
			near_errored_block_count_out <= ebc_con_in ? ebc_in : 16'hFFFF;
			multiframe_present_out       <= mfp_in;
			near_ds_connected_out        <= ds_con_in;
			near_ebc_connected_out       <= ebc_con_in;
		end
	end
endmodule
